// ==== hdl/hbf_pkg.sv ====
package hbf_pkg;

  // ==========================================================
  // Constants
  localparam logic [7:0] HBF_FEATURE_ID = 8'h0D;
  localparam int HBF_EN_BIT = 0;
  localparam int HBF_MR_BIT = 1;
  localparam int HBF_ALIGN_BITS = 4;
  localparam int HBF_ENTRY_SHIFT = 4;
  localparam int HBF_BASE_LSB = 0;
  localparam int HBF_PAGES_LSB = 64;
  localparam logic HBF_ENABLED_RST = 1'b0;
  localparam int HBF_ENTRY_BITS = 128;

  // ==========================================================
  // Types
  typedef struct packed {
    logic is_get;
    logic [7:0] fid;
    logic [31:0] dw11;
    logic [31:0] dw12;
    logic [31:0] dw13;
    logic [31:0] dw14;
    logic [31:0] dw15;
  } hbf_cmd_t;

  typedef struct packed {
    logic [31:0] size;
    logic [63:0] list_addr;
    logic [31:0] entry_count;
  } hbf_attr_t;

  typedef struct packed {
    logic [63:0] entry_base_address;
    logic [31:0] entry_page_count;
  } hbf_desc_t;

  typedef enum logic [1:0] {
    HBF_ST_OK = 2'h0,
    HBF_ST_SEQ_ERR = 2'h1,
    HBF_ST_BAD_FID = 2'h2
  } hbf_status_t;

endpackage

// ==== hdl/hbf_ctrl.sv ====
`timescale 1ns/1ps
module hbf_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire hbf_pkg::hbf_cmd_t cmd,
  output logic cmd_ready,
  output logic cpl_valid,
  output hbf_pkg::hbf_status_t cpl_status,
  output logic [31:0] cpl_dw0,
  output hbf_pkg::hbf_attr_t cpl_attr,
  output logic rd_req_valid,
  output logic [63:0] rd_req_addr,
  input wire logic rd_req_ready,
  input wire logic rd_resp_valid,
  input wire logic [127:0] rd_resp_data,
  output logic desc_valid,
  output hbf_pkg::hbf_desc_t desc,
  input wire logic buf_pending,
  output logic buf_use_allowed,
  output logic buf_contents_valid,
  output logic buffer_enable_flag
);
  import hbf_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_FREQ = 5'h02,
    S_FWAIT = 5'h04,
    S_DRAIN = 5'h08,
    S_CPL = 5'h10
  } hbf_state_t;

  hbf_state_t state_reg, state_next;
  hbf_attr_t attr_reg, attr_next;
  logic [31:0] idx_reg, idx_next;
  logic enabled_reg, enabled_next;
  logic allow_reg, allow_next;
  logic mr_reg, mr_next;
  logic pend_en_reg, pend_en_next;
  hbf_status_t status_reg, status_next;
  logic [31:0] dw0_reg, dw0_next;
  hbf_attr_t cattr_reg, cattr_next;
  logic desc_valid_reg, desc_valid_next;
  hbf_desc_t desc_reg, desc_next;
  logic [63:0] addr_reg, addr_next;
  logic [31:0] idx_next_inc;
  logic cvalid_reg, cvalid_next;

  // ==========================================================
  // Decode
  wire accept = cmd_valid && cmd_ready;
  wire fid_hit = (cmd.fid == HBF_FEATURE_ID);
  wire req_en = cmd.dw11[HBF_EN_BIT];
  wire req_mr = cmd.dw11[HBF_MR_BIT];
  wire [31:0] lo_masked = {cmd.dw13[31:HBF_ALIGN_BITS], {HBF_ALIGN_BITS{1'b0}}};
  wire hbf_attr_t new_attr = '{size: cmd.dw12, list_addr: {cmd.dw14, lo_masked},
                               entry_count: cmd.dw15};
  wire [63:0] entry_addr = attr_reg.list_addr + {28'h0, idx_next_inc, 4'h0};
  wire last_entry = (idx_reg == attr_reg.entry_count - 32'h1);
  assign idx_next_inc = idx_reg + 32'h1;
  assign cvalid_next = allow_next && mr_next;

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    attr_next = attr_reg;
    idx_next = idx_reg;
    enabled_next = enabled_reg;
    allow_next = allow_reg;
    mr_next = mr_reg;
    pend_en_next = pend_en_reg;
    status_next = status_reg;
    dw0_next = dw0_reg;
    cattr_next = cattr_reg;
    desc_valid_next = 1'b0;
    desc_next = desc_reg;
    addr_next = addr_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (accept) begin
          state_next = S_CPL;
          status_next = HBF_ST_OK;
          dw0_next = 32'h0;
          cattr_next = '0;
          pend_en_next = enabled_reg;
          if (!fid_hit) begin
            status_next = HBF_ST_BAD_FID;
          end else if (cmd.is_get) begin
            dw0_next[HBF_EN_BIT] = enabled_reg;
            cattr_next = attr_reg;
          end else if (req_en && enabled_reg) begin
            status_next = HBF_ST_SEQ_ERR;
          end else if (req_en) begin
            attr_next = new_attr;
            mr_next = req_mr;
            idx_next = 32'h0;
            pend_en_next = 1'b1;
            if (cmd.dw15 != 32'h0) begin
              state_next = S_FREQ;
              addr_next = new_attr.list_addr;
            end
          end else if (enabled_reg) begin
            allow_next = 1'b0;
            pend_en_next = 1'b0;
            state_next = S_DRAIN;
          end
          // disable while disabled falls to OK
        end
      end
      S_FREQ: begin
        if (rd_req_ready) begin
          state_next = S_FWAIT;
        end
      end
      S_FWAIT: begin
        if (rd_resp_valid) begin
          desc_valid_next = 1'b1;
          desc_next.entry_base_address = rd_resp_data[HBF_BASE_LSB +: 64];
          desc_next.entry_page_count = rd_resp_data[HBF_PAGES_LSB +: 32];
          if (last_entry) begin
            state_next = S_CPL;
          end else begin
            idx_next = idx_next_inc;
            state_next = S_FREQ;
            addr_next = entry_addr;
          end
        end
      end
      S_DRAIN: begin
        if (!buf_pending) begin
          state_next = S_CPL;
        end
      end
      S_CPL: begin
        enabled_next = pend_en_reg;
        allow_next = pend_en_reg;
        state_next = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      attr_reg <= '0;
      idx_reg <= 32'h0;
      enabled_reg <= HBF_ENABLED_RST;
      allow_reg <= 1'b0;
      mr_reg <= 1'b0;
      pend_en_reg <= 1'b0;
      status_reg <= HBF_ST_OK;
      dw0_reg <= 32'h0;
      cattr_reg <= '0;
      desc_valid_reg <= 1'b0;
      desc_reg <= '0;
      addr_reg <= 64'h0;
      cvalid_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      attr_reg <= attr_next;
      idx_reg <= idx_next;
      enabled_reg <= enabled_next;
      allow_reg <= allow_next;
      mr_reg <= mr_next;
      pend_en_reg <= pend_en_next;
      status_reg <= status_next;
      dw0_reg <= dw0_next;
      cattr_reg <= cattr_next;
      desc_valid_reg <= desc_valid_next;
      desc_reg <= desc_next;
      addr_reg <= addr_next;
      cvalid_reg <= cvalid_next;
    end
  end

  // ==========================================================
  // Outputs
  assign cmd_ready = state_reg[0];
  assign rd_req_valid = state_reg[1];
  assign cpl_valid = state_reg[4];
  assign cpl_status = status_reg;
  assign cpl_dw0 = dw0_reg;
  assign cpl_attr = cattr_reg;
  assign rd_req_addr = addr_reg;
  assign desc_valid = desc_valid_reg;
  assign desc = desc_reg;
  assign buf_use_allowed = allow_reg;
  assign buf_contents_valid = cvalid_reg;
  assign buffer_enable_flag = enabled_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  hbf_cmd_t held_cmd;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_cmd <= '0;
    end else if (clk_en && accept) begin
      held_cmd <= cmd;
    end
  end
  wire held_set = held_cmd.fid == HBF_FEATURE_ID && !held_cmd.is_get;

  // Previous descriptor request of this enable
  logic [63:0] last_addr_reg;
  logic prev_seen_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_addr_reg <= 64'h0;
      prev_seen_reg <= 1'b0;
    end else if (clk_en && accept) begin
      prev_seen_reg <= 1'b0;
    end else if (clk_en && rd_req_valid && rd_req_ready) begin
      last_addr_reg <= rd_req_addr;
      prev_seen_reg <= 1'b1;
    end
  end

  a_seq_err_cause: assert property (
    cpl_valid && cpl_status == HBF_ST_SEQ_ERR |-> held_set && held_cmd.dw11[0]
      && buffer_enable_flag)
    else $error("sequence error without double enable");

  a_double_enable: assert property (
    cpl_valid && held_set && held_cmd.dw11[0] && buffer_enable_flag
      |-> cpl_status == HBF_ST_SEQ_ERR)
    else $error("double enable not refused");

  a_disable_noop: assert property (
    clk_en && cpl_valid && held_set && !held_cmd.dw11[0] |-> cpl_status == HBF_ST_OK
      ##1 !buffer_enable_flag)
    else $error("disable did not leave buffer off");

  a_no_use_off: assert property (
    !buffer_enable_flag && !cpl_valid |-> !buf_use_allowed)
    else $error("buffer used while disabled");

  a_drain_first: assert property (
    cpl_valid && held_set && !held_cmd.dw11[0] && buffer_enable_flag
      |-> !$past(buf_pending) && !buf_use_allowed)
    else $error("disable completion with pending access");

  a_addr_align: assert property (
    rd_req_valid |-> rd_req_addr[3:0] == 4'h0)
    else $error("descriptor read misaligned");

  a_get_state: assert property (
    cpl_valid && held_cmd.fid == HBF_FEATURE_ID && held_cmd.is_get
      |-> cpl_dw0[0] == buffer_enable_flag && cpl_attr == attr_reg)
    else $error("get reports wrong state");

  a_flag_on_cpl: assert property (
    clk_en && !cpl_valid |=> $stable(buffer_enable_flag))
    else $error("enable flag changed outside completion");

  a_fid_reject: assert property (
    cpl_valid && held_cmd.fid != HBF_FEATURE_ID |-> cpl_status == HBF_ST_BAD_FID)
    else $error("foreign feature accepted");

  a_ignore_attrs: assert property (
    clk_en && accept && !cmd.is_get && !cmd.dw11[HBF_EN_BIT] |=> $stable(attr_reg))
    else $error("disable changed buffer attributes");

  a_desc_pulse: assert property (
    clk_en && desc_valid |=> !desc_valid)
    else $error("descriptor strobe too long");

  sequence s_fetch_beat;
    rd_req_valid && rd_req_ready && clk_en;
  endsequence
  sequence s_next_fetch;
    rd_req_valid && prev_seen_reg;
  endsequence
  a_fetch_stride: assert property (
    s_next_fetch |-> rd_req_addr == last_addr_reg + 64'h10)
    else $error("descriptor stride wrong");

  a_one_outstanding: assert property (
    s_fetch_beat |=> !rd_req_valid)
    else $error("second descriptor read while one outstanding");

endmodule

// ==== test/hbf_host_mem.sv ====
`timescale 1ns/1ps
// ==========
// Host memory model
module hbf_host_mem (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic rd_req_valid,
  input wire logic [63:0] rd_req_addr,
  output logic rd_req_ready,
  output logic rd_resp_valid,
  output logic [127:0] rd_resp_data
);
  logic tick_reg;
  logic hs;
  // list unchanged, entry made from its address
  // reserved ones, page count, page-aligned base
  function automatic logic [127:0] entry(input logic [63:0] a);
    return {32'hFFFF_FFFF, a[35:4] + 32'h1, a[51:0], 12'h000};
  endfunction
  assign hs = rd_req_valid & rd_req_ready;
  assign rd_req_ready = rd_req_valid & (~slow | tick_reg);
  // address taken as sent, already aligned
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_reg <= 1'b0;
      rd_resp_valid <= 1'b0;
      rd_resp_data <= '0;
    end else begin
      tick_reg <= ~tick_reg;
      rd_resp_valid <= hs;
      rd_resp_data <= hs ? entry(rd_req_addr) : ~rd_resp_data;
    end
  end
endmodule

// ==== test/host_buffer_feature_control_tb_top.sv ====
`timescale 1ns/1ps
module host_buffer_feature_control_tb_top;
  import hbf_pkg::*;
  typedef struct packed {hbf_cmd_t c; hbf_status_t st; logic en;} hbf_row_t;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic clk_en = 1;
  logic cmd_valid = 0;
  hbf_cmd_t cmd = '0;
  logic buf_pending = 0;
  logic slow = 0;
  logic cmd_ready, cpl_valid, rd_req_valid, rd_req_ready, rd_resp_valid, desc_valid;
  logic buf_use_allowed, buf_contents_valid, buffer_enable_flag;
  hbf_status_t cpl_status;
  logic [31:0] cpl_dw0;
  hbf_attr_t cpl_attr, la;
  logic [63:0] rd_req_addr, ra, pa;
  logic [127:0] rd_resp_data;
  hbf_desc_t desc;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_desc = 0;
  hbf_row_t rows [8];

  always #5 core_clk = ~core_clk;

  hbf_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .cpl_dw0(cpl_dw0), .cpl_attr(cpl_attr),
    .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready),
    .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data), .desc_valid(desc_valid),
    .desc(desc), .buf_pending(buf_pending), .buf_use_allowed(buf_use_allowed),
    .buf_contents_valid(buf_contents_valid), .buffer_enable_flag(buffer_enable_flag));

  hbf_host_mem mem (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready),
    .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data));

  // ==========
  // Tasks
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks_done++;
    if (g !== e) begin
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      n_fail++;
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic hbf_row_t mk(logic g, logic [7:0] f, logic [31:0] a, logic [31:0] b,
      logic [31:0] d, logic [31:0] h, logic [31:0] n, hbf_status_t st, logic en);
    return {g, f, a, b, d, h, n, st, en};
  endfunction

  task automatic run(input hbf_cmd_t c);
    int k;
    @(negedge core_clk);
    cmd = c;
    cmd_valid = 1;
    if (!c.is_get && c.dw11[0]) ra = {c.dw14, c.dw13[31:4], 4'h0};
    for (k = 0; cmd_ready !== 1'b1 && k < 100; k++) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 0;
    for (k = 0; cpl_valid !== 1'b1 && k < 300; k++) @(negedge core_clk);
    if (cpl_valid !== 1'b1) n_fail++;
  endtask

  // ==========
  // Monitor and timeout
  always @(negedge core_clk) begin
    if (desc_valid === 1'b1) begin
      n_desc++;
      chk(desc, {pa[51:0], 12'h000, pa[35:4] + 32'h1});
    end
    if (rd_req_valid === 1'b1 && rd_req_ready === 1'b1) begin
      chk(rd_req_addr, ra);
      pa = ra;
      ra = ra + 64'h10;
    end
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      wrap_up;
    end
  end

  // ==========
  // Sequence
  initial begin
    rows = '{mk(1, 8'h0D, 0, 0, 0, 0, 0, HBF_ST_OK, 0),
      mk(0, 8'h0D, 32'hFFFF_FFFC, 32'hDEAD_BEEF, 1, 2, 3, HBF_ST_OK, 0),
      mk(0, 8'h0E, 1, 4, 32'h40, 0, 1, HBF_ST_BAD_FID, 0),
      mk(0, 8'h0D, 1, 32'h10, 32'h0000_123F, 1, 3, HBF_ST_OK, 1),
      mk(0, 8'h0D, 1, 5, 6, 7, 1, HBF_ST_SEQ_ERR, 1),
      mk(1, 8'h0D, 0, 0, 0, 0, 0, HBF_ST_OK, 1),
      mk(0, 8'h0D, 0, 9, 9, 9, 9, HBF_ST_OK, 0),
      mk(0, 8'h0D, 3, 8, 0, 0, 0, HBF_ST_OK, 1)};
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 0;
    foreach (rows[i]) begin
      run(rows[i].c);
      chk(cpl_status, rows[i].st);
      if (rows[i].c.is_get) chk(cpl_dw0, {31'h0, rows[i].en});
      if (rows[i].c.is_get && rows[i].en) chk(cpl_attr, la);
      if (rows[i].st == HBF_ST_OK && rows[i].c.dw11[0])
        la = {rows[i].c.dw12, rows[i].c.dw14, rows[i].c.dw13[31:4], 4'h0, rows[i].c.dw15};
      @(negedge core_clk);
      chk(buffer_enable_flag, rows[i].en);
      chk(buf_use_allowed, rows[i].en);
    end
    chk(buf_contents_valid, 1);
    buf_pending = 1;
    fork
      run(rows[6].c);
      begin
        repeat (8) @(negedge core_clk);
        chk(cpl_valid, 0);
        chk(buf_use_allowed, 0);
        buf_pending = 0;
      end
    join
    chk(cpl_status, HBF_ST_OK);
    slow = 1;
    rows[0] = mk(0, 8'h0D, 1, 2, 32'h40, 1, 2, HBF_ST_OK, 1);
    run(rows[0].c);
    @(negedge core_clk);
    chk(buf_contents_valid, 0);
    chk(buffer_enable_flag, 1);
    chk(n_desc, 5);
    clk_en = 0;
    cmd = rows[6].c;
    cmd_valid = 1;
    repeat (3) @(negedge core_clk);
    chk(buffer_enable_flag, 1);
    chk(cpl_valid, 0);
    cmd_valid = 0;
    clk_en = 1;
    sys_rst = 1;
    @(negedge core_clk);
    chk(buffer_enable_flag, 0);
    chk(cmd_ready, 1);
    wrap_up;
  end
endmodule
